/* src/rps_slave.sv */
// Purpose: rear-port slave: request decode, blocking, events, cyclic timing, char check
// Assumes: requests, characters and control inputs come from logic on clk
// Notes:   register addresses arrive zero-based within a page
`timescale 1ns/100ps
`default_nettype none
module rps_slave #(
  parameter int SEC_CYCLES = rps_pkg::SEC_CYCLES_DFLT
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // configuration
  input  wire logic             mode_register,
  input  wire logic [7:0]       port_station_number,
  input  wire logic             port_bit_rate,
  input  wire logic [5:0]       measurement_interval,
  input  wire logic             optics_fitted,
  input  wire logic             port_media_select,
  input  wire logic [1:0]       comms_block_select,
  input  wire logic             parity_en,
  // internal signal bus
  input  wire logic             monitor_direction_inhibit,
  input  wire logic             command_direction_inhibit,
  input  wire logic             test_mode,
  input  wire logic             spont_in,
  // received character and decoded request
  input  wire logic             char_valid,
  input  wire logic [10:0]      char_bits,
  input  wire rps_pkg::rps_req_t req,
  // outputs
  output var  rps_pkg::rps_rsp_t rsp_r,
  output var  rps_pkg::rps_evt_t evt_r,
  output logic [15:0]           bit_cycles_r,
  output logic                  media_fibre_r,
  output logic [7:0]            char_data_r,
  output logic                  char_ok_r,
  output logic                  char_err_r
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rps_pkg::rps_rsp_t rsp_nxt;
  rps_pkg::rps_evt_t evt_nxt;
  logic [15:0]       bit_cycles_nxt;
  logic              media_fibre_nxt;
  logic [7:0]        char_data_nxt;
  logic              char_ok_nxt;
  logic              char_err_nxt;
  logic              test_r;
  logic [31:0]       sec_cnt_r;
  logic [31:0]       sec_cnt_nxt;
  logic [5:0]        meas_cnt_r;
  logic [5:0]        meas_cnt_nxt;
  logic [5:0]        interval;
  logic              sec_tick;
  logic              meas_tick;
  logic              taken;
  logic              mon_blk;
  logic              cmd_blk;

  // ----------------------------------------------------------------
  // blocking and addressing
  // ----------------------------------------------------------------
  assign mon_blk = (comms_block_select == rps_pkg::RPS_BLK_MON) && monitor_direction_inhibit;
  assign cmd_blk = (comms_block_select == rps_pkg::RPS_BLK_CMD) && command_direction_inhibit;
  // station 255 lies outside the legal range, so nothing is answered then
  assign taken = req.valid && (port_station_number <= rps_pkg::STATION_MAX)
               && (req.station == port_station_number);

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  always_comb
  begin
    rsp_nxt       = '0;
    rsp_nxt.valid = taken;
    rsp_nxt.kind  = rps_pkg::RPS_RSP_DATA;
    if (mode_register)
    begin
      // binary framing only; the decoded request carries the raw code
      rsp_nxt.kind   = rps_pkg::RPS_RSP_REG_OK;
      rsp_nxt.addr   = req.addr;
      rsp_nxt.count  = req.count;
      rsp_nxt.access = 1'b1;
      case (req.fcode)
        rps_pkg::FC_RD_COILS:  rsp_nxt.page = rps_pkg::PAGE_CONTACTS;
        rps_pkg::FC_RD_INPUTS: rsp_nxt.page = rps_pkg::PAGE_OPTOS;
        rps_pkg::FC_RD_HOLD:   rsp_nxt.page = rps_pkg::PAGE_SETTINGS;
        rps_pkg::FC_RD_INREG:  rsp_nxt.page = rps_pkg::PAGE_MEAS;
        rps_pkg::FC_WR_SINGLE:
        begin
          rsp_nxt.page  = rps_pkg::PAGE_SETTINGS;
          rsp_nxt.write = 1'b1;
          rsp_nxt.count = 8'h01;
        end
        rps_pkg::FC_WR_MULTI:
        begin
          rsp_nxt.page  = rps_pkg::PAGE_SETTINGS;
          rsp_nxt.write = 1'b1;
          if (req.count == 8'h00 || req.count > rps_pkg::MAX_MULTI_REGS)
          begin
            rsp_nxt.kind   = rps_pkg::RPS_RSP_REG_EXC;
            rsp_nxt.exc    = rps_pkg::EXC_ILL_VALUE;
            rsp_nxt.access = 1'b0;
            rsp_nxt.write  = 1'b0;
          end
        end
        rps_pkg::FC_DIAG, rps_pkg::FC_EV_COUNT, rps_pkg::FC_EV_LOG:
          rsp_nxt.access = 1'b0;
        default:
        begin
          rsp_nxt.kind   = rps_pkg::RPS_RSP_REG_EXC;
          rsp_nxt.exc    = rps_pkg::EXC_ILL_FUNC;
          rsp_nxt.access = 1'b0;
        end
      endcase
    end
    else
    begin
      case (req.kind)
        rps_pkg::RPS_REQ_GI, rps_pkg::RPS_REQ_STATUS:
          if (mon_blk)
          begin
            rsp_nxt.kind  = rps_pkg::RPS_RSP_GI_END;
            rsp_nxt.cause = rps_pkg::COT_GI_END;
          end
          else
            rsp_nxt.cause = test_mode ? rps_pkg::COT_TEST : rps_pkg::COT_GI;
        rps_pkg::RPS_REQ_DIST:
          if (mon_blk)
          begin
            rsp_nxt.kind  = rps_pkg::RPS_RSP_GI_END;
            rsp_nxt.cause = rps_pkg::COT_GI_END;
          end
          else if (req.rec_num >= rps_pkg::MAX_DIST_RECS)
          begin
            rsp_nxt.kind  = rps_pkg::RPS_RSP_ID1_NACK;
            rsp_nxt.cause = rps_pkg::COT_NACK;
          end
          else
          begin
            rsp_nxt.cause = rps_pkg::COT_DIST;
            rsp_nxt.count = {4'h0, req.rec_num};
          end
        rps_pkg::RPS_REQ_CMD:
          if (cmd_blk)
          begin
            rsp_nxt.kind  = rps_pkg::RPS_RSP_CMD_NACK;
            rsp_nxt.cause = rps_pkg::COT_NACK;
          end
          else
            rsp_nxt.cause = rps_pkg::COT_ACK;
        default:
        begin
          rsp_nxt.kind  = rps_pkg::RPS_RSP_ID1_NACK;
          rsp_nxt.cause = rps_pkg::COT_NACK;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // cyclic timing, events, port setup, character check
  // ----------------------------------------------------------------
  always_comb
  begin
    interval = measurement_interval;
    if (interval < rps_pkg::MEAS_MIN_S)
      interval = rps_pkg::MEAS_MIN_S;
    else if (interval > rps_pkg::MEAS_MAX_S)
      interval = rps_pkg::MEAS_MAX_S;
  end

  assign sec_tick  = (sec_cnt_r == 32'(SEC_CYCLES - 1));
  assign meas_tick = sec_tick && (meas_cnt_r + 6'h01 >= interval);

  always_comb
  begin
    sec_cnt_nxt  = sec_tick ? '0 : sec_cnt_r + 32'h1;
    meas_cnt_nxt = meas_cnt_r;
    if (meas_tick)
      meas_cnt_nxt = '0;
    else if (sec_tick)
      meas_cnt_nxt = meas_cnt_r + 6'h01;
    evt_nxt = '0;
    if (test_mode != test_r)
    begin
      evt_nxt.valid       = 1'b1;
      evt_nxt.test_change = 1'b1;
      evt_nxt.cause       = rps_pkg::COT_TEST;
    end
    else if (meas_tick)
    begin
      evt_nxt.valid  = 1'b1;
      evt_nxt.cyclic = 1'b1;
      evt_nxt.cause  = test_mode ? rps_pkg::COT_TEST : rps_pkg::COT_CYCLIC;
    end
    else if (spont_in)
    begin
      evt_nxt.valid = 1'b1;
      evt_nxt.cause = test_mode ? rps_pkg::COT_TEST : rps_pkg::COT_SPONT;
    end
    bit_cycles_nxt  = port_bit_rate ? rps_pkg::BIT_CYC_HI : rps_pkg::BIT_CYC_LO;
    media_fibre_nxt = optics_fitted && port_media_select;
    char_data_nxt   = char_valid ? char_bits[8:1] : char_data_r;
    char_ok_nxt     = 1'b0;
    char_err_nxt    = 1'b0;
    if (char_valid)
    begin
      // bit 0 start, 8:1 data, 9 even parity or first stop, 10 stop
      if (!char_bits[0] && char_bits[10] && (parity_en ? !(^char_bits[9:1]) : char_bits[9]))
        char_ok_nxt = 1'b1;
      else
        char_err_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rsp_r         <= '0;
      evt_r         <= '0;
      test_r        <= 1'b0;
      sec_cnt_r     <= '0;
      meas_cnt_r    <= '0;
      bit_cycles_r  <= rps_pkg::BIT_CYC_RST;
      media_fibre_r <= 1'b0;
      char_data_r   <= '0;
      char_ok_r     <= 1'b0;
      char_err_r    <= 1'b0;
    end
    else
    begin
      rsp_r         <= rsp_nxt;
      evt_r         <= evt_nxt;
      test_r        <= test_mode;
      sec_cnt_r     <= sec_cnt_nxt;
      meas_cnt_r    <= meas_cnt_nxt;
      bit_cycles_r  <= bit_cycles_nxt;
      media_fibre_r <= media_fibre_nxt;
      char_data_r   <= char_data_nxt;
      char_ok_r     <= char_ok_nxt;
      char_err_r    <= char_err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_test_edge_event: assert property ($changed(test_mode) |=> evt_r.valid && evt_r.test_change)
    else $error("test mode change gave no event");
  a_test_cause: assert property (test_mode && spont_in |=> evt_r.cause == rps_pkg::COT_TEST)
    else $error("event in test mode lacks test cause");
  a_dist_limit: assert property (taken && !mode_register && !mon_blk
      && req.kind == rps_pkg::RPS_REQ_DIST && req.rec_num >= rps_pkg::MAX_DIST_RECS
      |=> rsp_r.kind == rps_pkg::RPS_RSP_ID1_NACK)
    else $error("record beyond limit offered");
  a_mon_block: assert property (taken && !mode_register && mon_blk
      && req.kind == rps_pkg::RPS_REQ_STATUS |=> rsp_r.kind == rps_pkg::RPS_RSP_GI_END)
    else $error("monitor block not honoured");
  a_cmd_block: assert property (taken && !mode_register && cmd_blk
      && req.kind == rps_pkg::RPS_REQ_CMD
      |=> rsp_r.kind == rps_pkg::RPS_RSP_CMD_NACK && rsp_r.cause == rps_pkg::COT_NACK)
    else $error("command block not honoured");
  a_station_filter: assert property (req.valid && req.station != port_station_number
      |=> !rsp_r.valid)
    else $error("answered a foreign station");
  a_multi_limit: assert property (taken && mode_register && req.fcode == rps_pkg::FC_WR_MULTI
      && req.count > rps_pkg::MAX_MULTI_REGS |=> !rsp_r.access && rsp_r.exc == rps_pkg::EXC_ILL_VALUE)
    else $error("oversize multiple write accepted");
  a_page_hold: assert property (taken && mode_register && req.fcode == rps_pkg::FC_RD_HOLD
      |=> rsp_r.page == rps_pkg::PAGE_SETTINGS && rsp_r.addr == $past(req.addr))
    else $error("holding read on wrong page");
  a_bad_func: assert property (taken && mode_register && req.fcode == 8'h05
      |=> rsp_r.kind == rps_pkg::RPS_RSP_REG_EXC && !rsp_r.access)
    else $error("unsupported code not refused");
  a_meas_spacing: assert property (evt_r.cyclic |-> meas_cnt_r == 6'h00)
    else $error("cyclic frame out of step");
  a_char_frame: assert property (char_valid && char_bits[0] |=> char_err_r && !char_ok_r)
    else $error("bad start bit accepted");

  c_cyclic: cover property (evt_r.cyclic);
  c_gi_end: cover property (rsp_r.valid && rsp_r.kind == rps_pkg::RPS_RSP_GI_END);
  c_reg_write: cover property (rsp_r.valid && rsp_r.write);
  c_test_event: cover property (evt_r.test_change);

endmodule : rps_slave
`default_nettype wire

/* src/rps_pkg.sv */
// Purpose: constants and carrier types for the rear-port telecontrol/register slave
// Assumes: 100 MHz core clock
// Notes:   causes and codes follow the two serial protocols carried on the port
package rps_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          SEC_NS          = 1_000_000_000;
  localparam int          SEC_CYCLES_DFLT = SEC_NS / CLK_PERIOD_NS;
  localparam int          RATE_LO_BPS     = 9600;
  localparam int          RATE_HI_BPS     = 19200;
  localparam logic [15:0] BIT_CYC_LO      = 16'(SEC_NS / CLK_PERIOD_NS / RATE_LO_BPS);
  localparam logic [15:0] BIT_CYC_HI      = 16'(SEC_NS / CLK_PERIOD_NS / RATE_HI_BPS);
  localparam logic [5:0]  MEAS_MIN_S      = 6'h01;
  localparam logic [5:0]  MEAS_MAX_S      = 6'h3c;
  // ----------------------------------------------------------------
  // limits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  STATION_MAX     = 8'hfe;
  localparam logic [3:0]  MAX_DIST_RECS   = 4'h8;
  localparam logic [7:0]  MAX_MULTI_REGS  = 8'h7f;
  localparam logic [15:0] BIT_CYC_RST     = BIT_CYC_LO;
  localparam logic [5:0]  MEAS_RST_S      = 6'h01;
  // ----------------------------------------------------------------
  // transmission causes
  // ----------------------------------------------------------------
  localparam logic [7:0]  COT_SPONT       = 8'h01;
  localparam logic [7:0]  COT_CYCLIC      = 8'h02;
  localparam logic [7:0]  COT_TEST        = 8'h07;
  localparam logic [7:0]  COT_GI          = 8'h09;
  localparam logic [7:0]  COT_GI_END      = 8'h0a;
  localparam logic [7:0]  COT_ACK         = 8'h14;
  localparam logic [7:0]  COT_NACK        = 8'h15;
  localparam logic [7:0]  COT_DIST        = 8'h1f;
  // ----------------------------------------------------------------
  // register-access function codes, pages, exceptions
  // ----------------------------------------------------------------
  localparam logic [7:0]  FC_RD_COILS     = 8'h01;
  localparam logic [7:0]  FC_RD_INPUTS    = 8'h02;
  localparam logic [7:0]  FC_RD_HOLD      = 8'h03;
  localparam logic [7:0]  FC_RD_INREG     = 8'h04;
  localparam logic [7:0]  FC_WR_SINGLE    = 8'h06;
  localparam logic [7:0]  FC_DIAG         = 8'h08;
  localparam logic [7:0]  FC_EV_COUNT     = 8'h0b;
  localparam logic [7:0]  FC_EV_LOG       = 8'h0c;
  localparam logic [7:0]  FC_WR_MULTI     = 8'h10;
  localparam logic [2:0]  PAGE_CONTACTS   = 3'h0;
  localparam logic [2:0]  PAGE_OPTOS      = 3'h1;
  localparam logic [2:0]  PAGE_MEAS       = 3'h3;
  localparam logic [2:0]  PAGE_SETTINGS   = 3'h4;
  localparam logic [7:0]  EXC_ILL_FUNC    = 8'h01;
  localparam logic [7:0]  EXC_ILL_VALUE   = 8'h03;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RPS_BLK_OFF, RPS_BLK_MON, RPS_BLK_CMD} rps_blk_t;
  typedef enum logic [2:0] {
    RPS_REQ_GI, RPS_REQ_STATUS, RPS_REQ_DIST, RPS_REQ_CMD, RPS_REQ_OTHER, RPS_REQ_REG
  } rps_req_kind_t;
  typedef enum logic [2:0] {
    RPS_RSP_DATA, RPS_RSP_GI_END, RPS_RSP_CMD_NACK, RPS_RSP_ID1_NACK, RPS_RSP_REG_OK,
    RPS_RSP_REG_EXC
  } rps_rsp_kind_t;
  typedef struct packed {
    logic          valid;
    rps_req_kind_t kind;
    logic [7:0]    station;
    logic [7:0]    fcode;
    logic [15:0]   addr;
    logic [7:0]    count;
    logic [3:0]    rec_num;
  } rps_req_t;
  typedef struct packed {
    logic          valid;
    rps_rsp_kind_t kind;
    logic [7:0]    cause;
    logic          access;
    logic          write;
    logic [2:0]    page;
    logic [15:0]   addr;
    logic [7:0]    count;
    logic [7:0]    exc;
  } rps_rsp_t;
  typedef struct packed {
    logic       valid;
    logic       test_change;
    logic       cyclic;
    logic [7:0] cause;
  } rps_evt_t;
endpackage : rps_pkg

/* tb/rps_master_model.sv */
// Purpose: master-station model that issues requests and framed characters
// Assumes: tasks are called from the bench; every drive lands 1 ns after a rising edge
// Notes:   released fields are inverted so that stale values never look valid
`timescale 1ns/100ps
`default_nettype none
module rps_master_model (
  // clock
  input  wire logic              clk,
  // link side
  output var  rps_pkg::rps_req_t req,
  output logic                   char_valid,
  output logic [10:0]            char_bits
);
  initial
  begin
    req = '0;
    char_valid = 1'b0;
    char_bits = 11'h7ff;
  end

  // one request, held over the taking edge only
  task automatic send_req(input rps_pkg::rps_req_kind_t k, input logic [7:0] stn,
                          input logic [7:0] fc, input logic [15:0] a, input logic [7:0] cnt,
                          input logic [3:0] rec);
    @(posedge clk);
    #1;
    req = '{1'b1, k, stn, fc, a, cnt, rec};
    @(posedge clk);
    #1;
    req = rps_pkg::rps_req_t'({1'b0, ~req[$bits(req)-2:0]});
  endtask : send_req

  // fault bit 0 bad start, bit 1 bad parity or stop, bit 2 bad final stop
  task automatic send_char(input logic [7:0] d, input logic par_en, input logic [2:0] fault);
    logic b9;
    b9 = par_en ? ^d : 1'b1;
    @(posedge clk);
    #1;
    char_bits = {~fault[2], b9 ^ fault[1], d, fault[0]};
    char_valid = 1'b1;
    @(posedge clk);
    #1;
    char_valid = 1'b0;
    char_bits = ~char_bits;
  endtask : send_char
endmodule : rps_master_model
`default_nettype wire

/* tb/rps_slave_test.sv */
// Purpose: self-checking bench for the rear-port slave
// Assumes: short second of SEC clocks
// Notes:   random stimulus from a fixed seed plus hand-picked corners
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      err_count++; \
      $display("[ERR] %0t got %h expected %h", $time, (a), (b)); \
    end \
  end
module rps_slave_test;
  localparam int SEC = 10;
  logic                  clk, reset, mode_register, port_bit_rate, optics_fitted;
  logic                  port_media_select, parity_en, test_mode, spont_in, exp_v;
  logic                  monitor_direction_inhibit, command_direction_inhibit;
  logic                  char_valid, char_ok_r, char_err_r, media_fibre_r;
  logic [1:0]            comms_block_select;
  logic [3:0]            rec;
  logic [5:0]            measurement_interval;
  logic [7:0]            port_station_number, stn, fc, cnt, char_data_r, e;
  logic [10:0]           char_bits;
  logic [15:0]           bit_cycles_r;
  logic [31:0]           seed, r;
  rps_pkg::rps_req_t     req;
  rps_pkg::rps_rsp_t     rsp;
  rps_pkg::rps_evt_t     evt;
  rps_pkg::rps_req_kind_t k;
  int                    err_count, comparisons, n;
  logic [7:0]            fcs [14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0b,
                                      8'h0c, 8'h10, 8'h10, 8'h10, 8'h10, 8'h05, 8'hff};
  logic [5:0]            ivs [5] = '{6'h00, 6'h01, 6'h03, 6'h3c, 6'h3f};

  rps_slave #(.SEC_CYCLES(SEC)) DUT (.clk(clk), .reset(reset), .mode_register(mode_register),
    .port_station_number(port_station_number), .port_bit_rate(port_bit_rate),
    .measurement_interval(measurement_interval), .optics_fitted(optics_fitted),
    .port_media_select(port_media_select), .comms_block_select(comms_block_select),
    .parity_en(parity_en), .monitor_direction_inhibit(monitor_direction_inhibit),
    .command_direction_inhibit(command_direction_inhibit), .test_mode(test_mode),
    .spont_in(spont_in), .char_valid(char_valid), .char_bits(char_bits), .req(req),
    .rsp_r(rsp), .evt_r(evt), .bit_cycles_r(bit_cycles_r), .media_fibre_r(media_fibre_r),
    .char_data_r(char_data_r), .char_ok_r(char_ok_r), .char_err_r(char_err_r));
  rps_master_model m (.clk(clk), .req(req), .char_valid(char_valid), .char_bits(char_bits));

  // expected {kind, cause} of a telecontrol answer
  function automatic logic [10:0] tele_exp(input rps_pkg::rps_req_kind_t kd);
    logic mb, cb;
    mb = (comms_block_select == 2'h1) && monitor_direction_inhibit;
    cb = (comms_block_select == 2'h2) && command_direction_inhibit;
    case (kd)
      rps_pkg::RPS_REQ_GI, rps_pkg::RPS_REQ_STATUS:
        return mb ? {rps_pkg::RPS_RSP_GI_END, rps_pkg::COT_GI_END}
                  : {rps_pkg::RPS_RSP_DATA, test_mode ? rps_pkg::COT_TEST : rps_pkg::COT_GI};
      rps_pkg::RPS_REQ_DIST:
        return mb ? {rps_pkg::RPS_RSP_GI_END, rps_pkg::COT_GI_END}
             : (rec >= 4'h8) ? {rps_pkg::RPS_RSP_ID1_NACK, rps_pkg::COT_NACK}
             : {rps_pkg::RPS_RSP_DATA, rps_pkg::COT_DIST};
      rps_pkg::RPS_REQ_CMD:
        return cb ? {rps_pkg::RPS_RSP_CMD_NACK, rps_pkg::COT_NACK}
                  : {rps_pkg::RPS_RSP_DATA, rps_pkg::COT_ACK};
      default: return {rps_pkg::RPS_RSP_ID1_NACK, rps_pkg::COT_NACK};
    endcase
  endfunction : tele_exp

  // expected {kind, access, write, page} of a register answer
  function automatic logic [7:0] reg_exp(input logic [7:0] f, input logic [7:0] c);
    case (f)
      8'h01: return {rps_pkg::RPS_RSP_REG_OK, 2'b10, rps_pkg::PAGE_CONTACTS};
      8'h02: return {rps_pkg::RPS_RSP_REG_OK, 2'b10, rps_pkg::PAGE_OPTOS};
      8'h03: return {rps_pkg::RPS_RSP_REG_OK, 2'b10, rps_pkg::PAGE_SETTINGS};
      8'h04: return {rps_pkg::RPS_RSP_REG_OK, 2'b10, rps_pkg::PAGE_MEAS};
      8'h06: return {rps_pkg::RPS_RSP_REG_OK, 2'b11, rps_pkg::PAGE_SETTINGS};
      8'h10: return (c == 8'h00 || c > 8'h7f) ? {rps_pkg::RPS_RSP_REG_EXC, 5'h00}
                                             : {rps_pkg::RPS_RSP_REG_OK, 2'b11, 3'h4};
      8'h08, 8'h0b, 8'h0c: return {rps_pkg::RPS_RSP_REG_OK, 5'h00};
      default: return {rps_pkg::RPS_RSP_REG_EXC, 5'h00};
    endcase
  endfunction : reg_exp

  // one clock with test mode and a spontaneous pulse, then the event is visible
  task automatic step(input logic ts, input logic sp);
    @(posedge clk);
    #1;
    test_mode = ts;
    spont_in = sp;
    @(posedge clk);
    #1;
    spont_in = 1'b0;
  endtask : step

  task automatic wait_cyc(output int cyc);
    cyc = 0;
    do
    begin
      @(posedge clk);
      #1;
      cyc++;
    end while (!(evt.valid === 1'b1 && evt.cyclic === 1'b1) && cyc < 2000);
    `CHK(cyc < 2000, 1'b1)
  endtask : wait_cyc

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #(30000 * 10);
    err_count++;
    stop_test();
  end

  initial
  begin
    {err_count, comparisons} = '0;
    seed = 32'h19fe182e;
    {reset, mode_register, port_bit_rate, optics_fitted, port_media_select} = 5'b10000;
    {parity_en, test_mode, spont_in, monitor_direction_inhibit} = 4'b1000;
    {command_direction_inhibit, comms_block_select, port_station_number} = '0;
    measurement_interval = 6'h3c;
    repeat (10) @(posedge clk);
    `CHK(bit_cycles_r, rps_pkg::BIT_CYC_LO)
    #1;
    reset = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      {port_bit_rate, optics_fitted, port_media_select} = {i[0], i[1], i[0]};
      repeat (2) @(posedge clk);
      #1;
      `CHK(bit_cycles_r, i[0] ? rps_pkg::BIT_CYC_HI : rps_pkg::BIT_CYC_LO)
      `CHK(media_fibre_r, i[1] & i[0])
    end
    $display("test rate_media done");
    for (int i = 0; i < 64; i++)
    begin
      r = $random(seed);
      k = rps_pkg::rps_req_kind_t'(r[2:0] % 3'h5);
      {test_mode, command_direction_inhibit, monitor_direction_inhibit} = r[7:5];
      comms_block_select = r[4:3];
      rec = (i < 2) ? 4'h7 + 4'(i) : r[11:8];
      port_station_number = (i % 8 == 7) ? 8'hff : 8'(r[19:12] % 8'hff);
      stn = (r[21:20] != 2'h0) ? port_station_number : port_station_number + 8'h01;
      // hand corners: status read under monitor block, command under command block
      if (i == 2 || i == 3)
      begin
        k = (i == 2) ? rps_pkg::RPS_REQ_STATUS : rps_pkg::RPS_REQ_CMD;
        {comms_block_select, monitor_direction_inhibit, command_direction_inhibit} =
          {2'(i - 1), 2'b11};
        stn = port_station_number;
      end
      m.send_req(k, stn, 8'h00, r[31:16], 8'h00, rec);
      exp_v = (stn == port_station_number) && (port_station_number != 8'hff);
      `CHK(rsp.valid, exp_v)
      if (exp_v)
        `CHK({rsp.kind, rsp.cause}, tele_exp(k))
      if (exp_v && k == rps_pkg::RPS_REQ_DIST && rsp.kind == rps_pkg::RPS_RSP_DATA)
        `CHK(rsp.count, {4'h0, rec})
    end
    $display("test telecontrol done");
    mode_register = 1'b1;
    // the last telecontrol pass leaves station 255, which answers nothing
    port_station_number = 8'h2a;
    for (int i = 0; i < 28; i++)
    begin
      r = $random(seed);
      fc = fcs[i % 14];
      cnt = (i % 14 == 9) ? 8'h00 : (i % 14 == 10) ? 8'h7f : (i % 14 == 11) ? 8'h80 : r[7:0];
      e = reg_exp(fc, cnt);
      m.send_req(rps_pkg::RPS_REQ_REG, port_station_number, fc, r[31:16], cnt, 4'h0);
      `CHK({rsp.valid, rsp.kind, rsp.access, rsp.write}, {1'b1, e[7:3]})
      if (e[4])
        `CHK({rsp.page, rsp.addr}, {e[2:0], r[31:16]})
      if (e[7:5] == rps_pkg::RPS_RSP_REG_EXC)
        `CHK(rsp.exc, fc == 8'h10 ? rps_pkg::EXC_ILL_VALUE : rps_pkg::EXC_ILL_FUNC)
      if (fc == 8'h06)
        `CHK(rsp.count, 8'h01)
    end
    $display("test register done");
    {mode_register, test_mode} = 2'b00;
    wait_cyc(n);
    step(1'b0, 1'b1);
    `CHK({evt.valid, evt.test_change, evt.cyclic, evt.cause}, {3'b100, rps_pkg::COT_SPONT})
    step(1'b1, 1'b0);
    `CHK({evt.valid, evt.test_change, evt.cause}, {2'b11, rps_pkg::COT_TEST})
    step(1'b1, 1'b1);
    `CHK({evt.valid, evt.test_change, evt.cause}, {2'b10, rps_pkg::COT_TEST})
    wait_cyc(n);
    `CHK(evt.cause, rps_pkg::COT_TEST)
    step(1'b0, 1'b0);
    `CHK({evt.valid, evt.test_change, evt.cause}, {2'b11, rps_pkg::COT_TEST})
    $display("test events done");
    for (int i = 0; i < 5; i++)
    begin
      measurement_interval = ivs[i];
      wait_cyc(n);
      wait_cyc(n);
      `CHK(evt.cause, rps_pkg::COT_CYCLIC)
      wait_cyc(n);
      `CHK(n, SEC * (i == 0 ? 1 : i == 4 ? 60 : int'(ivs[i])))
    end
    $display("test cyclic done");
    for (int i = 0; i < 40; i++)
    begin
      r = $random(seed);
      parity_en = i[0];
      m.send_char(r[7:0], i[0], i[1] ? r[10:8] : 3'h0);
      exp_v = !(i[1] && r[10:8] != 3'h0);
      `CHK({char_ok_r, char_err_r}, {exp_v, ~exp_v})
      if (exp_v)
        `CHK(char_data_r, r[7:0])
    end
    $display("test characters done");
    stop_test();
  end
endmodule : rps_slave_test
`default_nettype wire
